// >>> core/aim_cmp_detect.sv
`timescale 1ns/100ps
module aim_cmp_detect #(
  parameter int POS_W = 32
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [POS_W-1:0] pos,
  input  wire logic [POS_W-1:0] lower,
  input  wire logic [POS_W-1:0] upper,
  aim_evt_if.cmp_src            evt
);
  logic ge_lo;
  logic ge_hi;
  logic ge_lo_r;
  logic ge_hi_r;
  logic primed_r;

  // Signed compare against both bounds
  assign ge_lo = $signed(pos) >= $signed(lower);
  assign ge_hi = $signed(pos) >= $signed(upper);

  // Previous results; first cycle after reset only primes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ge_lo_r  <= 1'b0;
      ge_hi_r  <= 1'b0;
      primed_r <= 1'b0;
    end else begin
      ge_lo_r  <= ge_lo;
      ge_hi_r  <= ge_hi;
      primed_r <= 1'b1;
    end
  end

  // Pulse when a condition becomes true
  assign evt.cmp_evt[0] = primed_r & ge_lo & ~ge_lo_r;
  assign evt.cmp_evt[1] = primed_r & ~ge_lo & ge_lo_r;
  assign evt.cmp_evt[2] = primed_r & ~ge_hi & ge_hi_r;
  assign evt.cmp_evt[3] = primed_r & ge_hi & ~ge_hi_r;
endmodule

// >>> core/aim_evt_if.sv
`timescale 1ns/100ps
// Event pulses of one axis, from the detectors to the merge logic
interface aim_evt_if #(
  parameter int N_CMP   = 4,
  parameter int N_PHASE = 3
);
  logic [N_CMP-1:0]   cmp_evt;
  logic [N_PHASE-1:0] phase_evt;
  modport cmp_src   (output cmp_evt);
  modport phase_src (output phase_evt);
  modport sink      (input cmp_evt, input phase_evt);
endinterface

// >>> core/aim_interrupt_merge.sv
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
// Operation
// - All axis requests are ORed onto one request output to the host.
// - Each factor of each axis has its own enable bit.
// - After reset every factor enable is cleared, so no interrupt rises.
// - Enable bit one lets its factor interrupt; zero masks it.
// - Count reaching or passing lower bound sets status bit 1 if enabled.
// - Count dropping below lower bound sets status bit 2 if enabled.
// - Below upper bound sets bit 3; at or above upper sets bit 4.
// - Cruise to deceleration transition sets status bit 5 if enabled.
// - Acceleration to cruise transition sets status bit 6 if enabled.
// - Drive completion sets status bit 7 if enabled.
// - An enabled factor sets its status bit and pulls the request low.
// - Host reads an axis status to clear it; the request is released once no axis has a status bit set.
module aim_interrupt_merge #(
  parameter int AXES  = aim_pkg::AXES,
  parameter int POS_W = aim_pkg::POS_W
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic [AXES*POS_W-1:0] logical_pos,
  input  wire logic [AXES*POS_W-1:0] real_pos,
  input  wire logic [AXES-1:0]       accel,
  input  wire logic [AXES-1:0]       cruise,
  input  wire logic [AXES-1:0]       decel,
  input  wire logic [AXES-1:0]       drive_busy,
  output logic                       irq_request_n,
  output logic                       irq_request_n_oe_n
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam int REG_W   = aim_pkg::REG_W;
  localparam int ADDR_W  = aim_pkg::ADDR_W;
  localparam int FACTORS = aim_pkg::FACTORS;
  localparam int IDXW    = aim_pkg::AXIS_IDXW;

  logic                        taken;
  logic                        rd_take;
  logic                        wr_take;
  logic                        addr_ok;
  logic [ADDR_W-1:0]           loc;
  logic                        in_axis;
  logic [IDXW-1:0]             rd_idx;
  logic [ADDR_W-1:0]           rd_off;
  logic [31:0]                 rd_word;

  logic                        wr_pend_r;
  logic [ADDR_W-1:0]           wr_addr_r;
  logic                        wr_in_axis;
  logic [IDXW-1:0]             wr_idx;
  logic [ADDR_W-1:0]           wr_off;

  logic [31:0]                 hrdata_r;
  logic                        hreadyout_r;
  logic                        hresp_r;
  logic                        irq_n_r;
  logic                        irq_oe_n_r;

  logic [AXES-1:0]             config_r;
  logic [AXES-1:0]             pending_r;
  logic [AXES-1:0]             pending_nxt;
  logic                        line_r;

  logic [AXES-1:0][REG_W-1:0]  status_all;
  logic [AXES-1:0][POS_W-1:0]  cmp_lo_all;
  logic [AXES-1:0][POS_W-1:0]  cmp_hi_all;

  // ----------------------------------------
  // Address phase decode
  // ----------------------------------------
  // Transfer accepted when selected, active and bus ready
  assign taken   = hsel & htrans[1] & hready;
  assign rd_take = taken & ~hwrite;
  assign wr_take = taken & hwrite & (hsize == aim_pkg::HSIZE_WORD);

  // Only the low window is mapped; the rest reads zero
  assign addr_ok = (haddr[31:ADDR_W] == '0);
  assign loc     = haddr[ADDR_W-1:0];
  assign in_axis = addr_ok & (loc < aim_pkg::OFF_CONFIG);
  assign rd_idx  = loc[aim_pkg::AXIS_SHFT +: IDXW];
  assign rd_off  = loc & aim_pkg::AXIS_MASK;

  // ----------------------------------------
  // Write data phase
  // ----------------------------------------
  // Address held for the data phase that follows
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end else begin
      wr_pend_r <= wr_take & addr_ok;
      if (wr_take) begin
        wr_addr_r <= loc;
      end
    end
  end

  // Decode of the held write address
  assign wr_in_axis = wr_pend_r & (wr_addr_r < aim_pkg::OFF_CONFIG);
  assign wr_idx     = wr_addr_r[aim_pkg::AXIS_SHFT +: IDXW];
  assign wr_off     = wr_addr_r & aim_pkg::AXIS_MASK;

  // ----------------------------------------
  // Per-axis event logic and registers
  // ----------------------------------------
  for (genvar a = 0; a < AXES; a++) begin : g_axis
    logic [POS_W-1:0]   pos_sel;
    logic [FACTORS-1:0] raw_evt;
    logic [FACTORS-1:0] gated_evt;
    logic [REG_W-1:0]   set_bits;
    logic [REG_W-1:0]   enable_r;
    logic [REG_W-1:0]   status_r;
    logic [REG_W-1:0]   status_nxt;
    logic [POS_W-1:0]   cmp_lo_r;
    logic [POS_W-1:0]   cmp_hi_r;
    logic               rd_clr;
    logic               wr_here;

    aim_evt_if #(
      .N_CMP   (aim_pkg::N_CMP),
      .N_PHASE (aim_pkg::N_PHASE)
    ) evt_bus ();

    // Logical or real count, chosen by software
    assign pos_sel = config_r[a] ? real_pos[a*POS_W +: POS_W]
                                 : logical_pos[a*POS_W +: POS_W];

    // Compare window detector
    aim_cmp_detect #(
      .POS_W (POS_W)
    ) u_cmp (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pos     (pos_sel),
      .lower   (cmp_lo_r),
      .upper   (cmp_hi_r),
      .evt     (evt_bus)
    );

    // Drive phase transition detector
    aim_phase_detect u_phase (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .accel      (accel[a]),
      .cruise     (cruise[a]),
      .decel      (decel[a]),
      .drive_busy (drive_busy[a]),
      .evt        (evt_bus)
    );

    // Factor order matches enable and status bit order
    assign raw_evt   = {evt_bus.phase_evt, evt_bus.cmp_evt};
    assign gated_evt = raw_evt & enable_r[aim_pkg::EN_BASE +: FACTORS];

    // Status bits to set this cycle
    always_comb begin
      set_bits = '0;
      set_bits[aim_pkg::ST_BASE +: FACTORS] = gated_evt;
    end

    // Read of this axis status clears it
    assign rd_clr = rd_take & in_axis & (rd_idx == a)
                  & (rd_off == aim_pkg::OFF_STATUS);

    // New event wins over a clearing read
    always_comb begin
      if (rd_clr) begin
        status_nxt = set_bits;
      end else begin
        status_nxt = status_r | set_bits;
      end
    end

    // Sticky status register
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        status_r <= aim_pkg::STATUS_RST;
      end else begin
        status_r <= status_nxt;
      end
    end

    // Write strobe for this axis
    assign wr_here = wr_in_axis & (wr_idx == a);

    // Enable register, cleared by reset
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        enable_r <= aim_pkg::ENABLE_RST;
      end else if (wr_here && wr_off == aim_pkg::OFF_ENABLE) begin
        enable_r <= hwdata[REG_W-1:0] & aim_pkg::EN_MASK;
      end
    end

    // Compare bounds
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cmp_lo_r <= aim_pkg::CMP_RST;
        cmp_hi_r <= aim_pkg::CMP_RST;
      end else if (wr_here) begin
        if (wr_off == aim_pkg::OFF_CMP_LO) begin
          cmp_lo_r <= hwdata[POS_W-1:0];
        end
        if (wr_off == aim_pkg::OFF_CMP_HI) begin
          cmp_hi_r <= hwdata[POS_W-1:0];
        end
      end
    end

    // Views for the read mux and request merge
    assign status_all[a]  = status_r;
    assign cmp_lo_all[a]  = cmp_lo_r;
    assign cmp_hi_all[a]  = cmp_hi_r;
    assign pending_nxt[a] = |status_nxt;
  end

  // ----------------------------------------
  // Global registers
  // ----------------------------------------
  // Count source select, one bit per axis
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config_r <= aim_pkg::CONFIG_RST;
    end else if (wr_pend_r && (wr_addr_r & aim_pkg::WORD_MASK) == aim_pkg::OFF_CONFIG) begin
      config_r <= hwdata[AXES-1:0];
    end
  end

  // Pending summary and request level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pending_r <= '0;
      line_r    <= 1'b0;
    end else begin
      pending_r <= pending_nxt;
      line_r    <= |pending_nxt;
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Enable register is write-only and reads zero
  always_comb begin
    rd_word = '0;
    if (in_axis) begin
      case (rd_off)
        aim_pkg::OFF_STATUS: begin
          rd_word[REG_W-1:0] = status_all[rd_idx];
        end
        aim_pkg::OFF_CMP_LO: begin
          rd_word[POS_W-1:0] = cmp_lo_all[rd_idx];
        end
        aim_pkg::OFF_CMP_HI: begin
          rd_word[POS_W-1:0] = cmp_hi_all[rd_idx];
        end
        default: begin
          rd_word = '0;
        end
      endcase
    end else if (addr_ok) begin
      case (loc & aim_pkg::WORD_MASK)
        aim_pkg::OFF_CONFIG: begin
          rd_word[AXES-1:0] = config_r;
        end
        aim_pkg::OFF_PENDING: begin
          rd_word[AXES-1:0]          = pending_r;
          rd_word[aim_pkg::PEND_LINE] = line_r;
        end
        default: begin
          rd_word = '0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Bus response
  // ----------------------------------------
  // Read data latched at the address phase, shown in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= '0;
    end else if (rd_take) begin
      hrdata_r <= rd_word;
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_r <= 1'b1;
      hresp_r     <= aim_pkg::HRESP_OKAY;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r     <= aim_pkg::HRESP_OKAY;
    end
  end

  // ----------------------------------------
  // Request pin
  // ----------------------------------------
  // Driven low while any axis is pending, floats otherwise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_n_r    <= 1'b1;
      irq_oe_n_r <= 1'b1;
    end else begin
      irq_n_r    <= ~(|pending_nxt);
      irq_oe_n_r <= ~(|pending_nxt);
    end
  end

  assign hrdata             = hrdata_r;
  assign hreadyout          = hreadyout_r;
  assign hresp              = hresp_r;
  assign irq_request_n      = irq_n_r;
  assign irq_request_n_oe_n = irq_oe_n_r;

endmodule

// >>> core/aim_phase_detect.sv
`timescale 1ns/100ps
module aim_phase_detect (
  input  wire logic    hclk,
  input  wire logic    hresetn,
  input  wire logic    accel,
  input  wire logic    cruise,
  input  wire logic    decel,
  input  wire logic    drive_busy,
  aim_evt_if.phase_src evt
);
  logic accel_r;
  logic cruise_r;
  logic busy_r;

  // Previous drive phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      accel_r  <= 1'b0;
      cruise_r <= 1'b0;
      busy_r   <= 1'b0;
    end else begin
      accel_r  <= accel;
      cruise_r <= cruise;
      busy_r   <= drive_busy;
    end
  end

  // Phase transition pulses
  assign evt.phase_evt[0] = cruise_r & decel;
  assign evt.phase_evt[1] = accel_r & cruise;
  assign evt.phase_evt[2] = busy_r & ~drive_busy;
endmodule

// >>> core/aim_pkg.sv
package aim_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int AXES      = 4;
  localparam int POS_W     = 32;
  localparam int REG_W     = 16;
  localparam int ADDR_W    = 8;
  localparam int FACTORS   = 7;
  localparam int N_CMP     = 4;
  localparam int N_PHASE   = 3;
  localparam int AXIS_SHFT = 4;
  localparam int AXIS_IDXW = 2;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  // Enables sit at 9..15, status at 1..7, same factor order
  localparam int EN_BASE   = 9;
  localparam int ST_BASE   = 1;
  localparam int PEND_LINE = 8;
  localparam logic [REG_W-1:0] EN_MASK = 16'hFE00;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFF_ENABLE  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CMP_LO  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CMP_HI  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_CONFIG  = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_PENDING = 8'h44;
  localparam logic [ADDR_W-1:0] AXIS_MASK   = 8'h0C;
  localparam logic [ADDR_W-1:0] WORD_MASK   = 8'hFC;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [REG_W-1:0] ENABLE_RST = 16'h0000;
  localparam logic [REG_W-1:0] STATUS_RST = 16'h0000;
  localparam logic [POS_W-1:0] CMP_RST    = 32'h0000_0000;
  localparam logic [AXES-1:0]  CONFIG_RST = 4'h0;

  // ----------------------------------------
  // Bus encodings
  // ----------------------------------------
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       HRESP_OKAY = 1'b0;
endpackage

// >>> tb/aim_host_model.sv
`timescale 1ns/100ps
// -----------------------------
// Host side: bus master, pulled-up request line
// -----------------------------
module aim_host_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  input  wire logic        irq_request_n,
  input  wire logic        irq_request_n_oe_n,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata,
  output logic             irq_wire
);
  // Pull-up wins while the device floats the line
  assign irq_wire = irq_request_n_oe_n ? 1'b1 : irq_request_n;
  // Idle bus
  initial begin
    hsel   = 1'b1;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // One single transfer; entered just after a rising edge
  task automatic xfer(input logic wr, input logic [31:0] adr, input logic [31:0] wd,
                      input logic [2:0] sz, output logic [31:0] rd);
    htrans <= 2'h2;
    haddr  <= adr;
    hwrite <= wr;
    hsize  <= sz;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    haddr  <= ~adr;
    hwdata <= wr ? wd : ~hwdata;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
    hwdata <= ~hwdata;
  endtask
endmodule

// >>> tb/aim_interrupt_merge_properties.sv
`timescale 1ns/100ps
// -----------------------------
// Request pin and register bus checks
// -----------------------------
module aim_interrupt_merge_properties #(
  parameter int AXES  = 4,
  parameter int POS_W = 32
) (
  input wire logic                  hclk,
  input wire logic                  hresetn,
  input wire logic                  hsel,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic [2:0]            hsize,
  input wire logic [31:0]           hwdata,
  input wire logic                  hready,
  input wire logic [31:0]           hrdata,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic [AXES*POS_W-1:0] logical_pos,
  input wire logic [AXES*POS_W-1:0] real_pos,
  input wire logic [AXES-1:0]       accel,
  input wire logic [AXES-1:0]       cruise,
  input wire logic [AXES-1:0]       decel,
  input wire logic [AXES-1:0]       drive_busy,
  input wire logic                  irq_request_n,
  input wire logic                  irq_request_n_oe_n
);
  logic rd_take, st_sel, en_sel, wr_seen_r;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Taken read and the register it names
  assign rd_take = hsel && htrans[1] && hready && !hwrite;
  assign st_sel  = (haddr[31:6] == 26'h000_0000) && (haddr[3:0] == 4'h4);
  assign en_sel  = (haddr[31:6] == 26'h000_0000) && (haddr[3:0] == 4'h0);
  // Any taken write since reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_seen_r <= 1'b0;
    end else if (hsel && htrans[1] && hready && hwrite) begin
      wr_seen_r <= 1'b1;
    end
  end
  a_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
    else $error("bus answer not zero-wait okay");
  a_pin_pair: assert property (irq_request_n == irq_request_n_oe_n)
    else $error("request value and enable disagree");
  a_quiet_after_reset: assert property (!wr_seen_r |-> irq_request_n_oe_n)
    else $error("request before any enable write");
  a_release_by_read: assert property ($rose(irq_request_n_oe_n) |-> $past(rd_take && st_sel))
    else $error("request released without status read");
  a_idle_status_zero: assert property (rd_take && st_sel && irq_request_n_oe_n |=> hrdata == 32'h0000_0000)
    else $error("status set while request floats");
  a_status_field: assert property (rd_take && st_sel |=> hrdata[31:8] == 24'h00_0000 && !hrdata[0])
    else $error("status bits outside field");
  a_enable_read_zero: assert property (rd_take && en_sel |=> hrdata == 32'h0000_0000)
    else $error("enable register readable");
  a_unmapped_zero: assert property (rd_take && haddr[31:8] != 24'h00_0000 |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_pending_pin: assert property (rd_take && haddr == 32'h0000_0044 |=>
    hrdata[8] == !$past(irq_request_n_oe_n) && (hrdata[3:0] != 4'h0) == hrdata[8])
    else $error("pending summary disagrees with request");
  c_irq_raised: cover property ($fell(irq_request_n_oe_n));
  c_read_pending: cover property (rd_take && st_sel && !irq_request_n_oe_n);
  c_irq_released: cover property ($rose(irq_request_n_oe_n));
endmodule
bind aim_interrupt_merge aim_interrupt_merge_properties #(.AXES(AXES), .POS_W(POS_W)) aim_interrupt_merge_properties_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .logical_pos(logical_pos), .real_pos(real_pos), .accel(accel), .cruise(cruise), .decel(decel),
  .drive_busy(drive_busy), .irq_request_n(irq_request_n), .irq_request_n_oe_n(irq_request_n_oe_n));

// >>> tb/tb_axis_interrupt_merge.sv
`timescale 1ns/100ps
module tb_axis_interrupt_merge;
  logic                hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq_request_n, irq_request_n_oe_n, irq_wire;
  logic [31:0]         haddr, hwdata, hrdata;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic [127:0]        logical_pos, real_pos;
  logic [3:0]          accel, cruise, decel, drive_busy;
  logic [3:0]          pf[4], pv[4];
  int                  num_errors = 0, cmp_count = 0, seed = 70768;
  int                  lp[4], rp[4], lo[4], hi[4], men[4], mst[4], mcfg, a, v, e;
  // Clock
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  aim_interrupt_merge aim_interrupt_merge_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .logical_pos(logical_pos), .real_pos(real_pos), .accel(accel), .cruise(cruise), .decel(decel),
    .drive_busy(drive_busy), .irq_request_n(irq_request_n), .irq_request_n_oe_n(irq_request_n_oe_n));
  aim_host_model aim_host_model_inst (
    .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .irq_request_n(irq_request_n),
    .irq_request_n_oe_n(irq_request_n_oe_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .irq_wire(irq_wire));
  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  function automatic logic [3:0] flags(input int x);
    int p;
    p = mcfg[x] ? rp[x] : lp[x];
    return {p >= hi[x], p < hi[x], p < lo[x], p >= lo[x]};
  endfunction
  task automatic upd(input int x);
    logic [3:0] f;
    f = flags(x);
    mst[x] |= (int'(f & ~pf[x]) << 1) & (men[x] >> 8);
    pf[x] = f;
  endtask
  task automatic mreset();
    mcfg = 0;
    lo = '{default: 0};
    hi = '{default: 0};
    men = '{default: 0};
    mst = '{default: 0};
    pv = '{default: 4'h0};
    for (int x = 0; x < 4; x++) pf[x] = flags(x);
  endtask
  function automatic int pend();
    int p;
    p = 0;
    for (int x = 0; x < 4; x++) if (mst[x] != 0) p |= 1 << x;
    return (p != 0) ? (p | 256) : 0;
  endfunction
  // ----------------------------------------
  // Checks and bus tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, ex, got);
    end
  endtask
  task automatic chk_irq();
    chk("irq_wire", pend() == 0, {31'h0000_0000, irq_wire});
  endtask
  task automatic wr(input int adr, input int d, input logic [2:0] sz = 3'h2);
    logic [31:0] r;
    aim_host_model_inst.xfer(1'b1, adr, d, sz, r);
    if (sz != 3'h2) return;
    if (adr == 64) mcfg = d & 15;
    else if (adr < 64 && (adr & 15) == 0) men[adr / 16] = d & 32'h0000_FE00;
    else if (adr < 64 && (adr & 15) == 8) lo[adr / 16] = d;
    else if (adr < 64 && (adr & 15) == 12) hi[adr / 16] = d;
    for (int x = 0; x < 4; x++) upd(x);
  endtask
  task automatic rd(input int adr, input int ex, input string what);
    logic [31:0] r;
    aim_host_model_inst.xfer(1'b0, adr, 32'h0000_0000, 3'h2, r);
    chk(what, ex, r);
    if (adr < 64 && (adr & 15) == 4) mst[adr / 16] = 0;
  endtask
  // Moves the selected count; the other source runs far away
  task automatic sp(input int x, input int p);
    logical_pos[x*32+:32] <= mcfg[x] ? p - 5000 : p;
    real_pos[x*32+:32] <= mcfg[x] ? p : p - 5000;
    lp[x] = mcfg[x] ? p - 5000 : p;
    rp[x] = mcfg[x] ? p : p - 5000;
    upd(x);
    repeat (2) @(posedge hclk);
  endtask
  // Drive phase levels {busy, decel, cruise, accel}
  task automatic ph(input int x, input logic [3:0] l);
    {drive_busy[x], decel[x], cruise[x], accel[x]} <= l;
    if (pv[x][1] && l[2]) mst[x] |= (1 << 5) & (men[x] >> 8);
    if (pv[x][0] && l[1]) mst[x] |= (1 << 6) & (men[x] >> 8);
    if (pv[x][3] && !l[3]) mst[x] |= (1 << 7) & (men[x] >> 8);
    pv[x] = l;
    repeat (2) @(posedge hclk);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (6000) @(posedge hclk);
    num_errors++;
    $display("unexpected timeout: expected done, seen hang");
    print_verdict();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    hresetn = 1'b0;
    logical_pos = '0;
    real_pos = '0;
    {accel, cruise, decel, drive_busy} = 16'h0000;
    mreset();
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_irq();
    for (a = 0; a < 4; a++) begin
      rd(a * 16, 0, "enable");
      rd(a * 16 + 4, 0, "status");
    end
    rd(32'h0000_0100, 0, "unmapped");
    rd(32'h0000_0044, 0, "pending");
    wr(32'h0000_0040, 32'h0000_0005);
    rd(32'h0000_0040, mcfg, "config");
    for (a = 0; a < 4; a++) begin
      v = $random(seed) % 1000;
      wr(a * 16 + 8, v);
      wr(a * 16 + 12, v + 100);
      rd(a * 16 + 8, lo[a], "lower");
      rd(a * 16 + 12, hi[a], "upper");
      sp(a, v - 50);
      rd(a * 16 + 4, mst[a], "status");
      wr(a * 16, 32'h0000_FE00);
      sp(a, v + 50);
      chk_irq();
      rd(a * 16 + 4, mst[a], "status");
      chk_irq();
      sp(a, v + 150);
      rd(a * 16 + 4, mst[a], "status");
      sp(a, v - 50);
      rd(a * 16 + 4, mst[a], "status");
    end
    wr(32'h0000_0010, 32'h0000_0200);
    wr(32'h0000_0010, 32'h0000_FE00, 3'h0);
    sp(1, lo[1] + 50);
    sp(1, lo[1] - 50);
    rd(32'h0000_0014, mst[1], "status");
    for (int k = 0; k < 2; k++) begin
      for (a = 0; a < 4; a++) begin
        e = k ? ($random(seed) & 32'h0000_FE00) : 32'h0000_E000;
        wr(a * 16, e);
        ph(a, 4'h9);
        ph(a, 4'hA);
        ph(a, 4'hC);
        ph(a, 4'h0);
        rd(a * 16 + 4, mst[a], "status");
      end
    end
    wr(32'h0000_0000, 32'h0000_8000);
    wr(32'h0000_0020, 32'h0000_8000);
    ph(0, 4'h8);
    ph(2, 4'h8);
    ph(0, 4'h0);
    ph(2, 4'h0);
    chk_irq();
    rd(32'h0000_0044, pend(), "pending");
    rd(32'h0000_0004, mst[0], "status");
    chk_irq();
    rd(32'h0000_0024, mst[2], "status");
    chk_irq();
    wr(32'h0000_0010, 32'h0000_8000);
    ph(1, 4'h8);
    ph(1, 4'h0);
    chk_irq();
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    mreset();
    @(posedge hclk);
    chk_irq();
    rd(32'h0000_0014, 0, "status");
    ph(1, 4'h8);
    ph(1, 4'h0);
    rd(32'h0000_0014, mst[1], "status");
    chk_irq();
    print_verdict();
  end
endmodule
